// *** pdcr_pkg.sv ***
// Purpose: constants and types for the clock multiplier and converter control bank
// Assumes: serial port frame of one instruction byte and then the data bytes, msb first
// Notes: offsets are the serial port register addresses

// ****************************************************************
// register map
// ****************************************************************
package pdcr_pkg;
  localparam int PDCR_ADDR_W = 5;
  localparam int PDCR_WORD_W = 24;
  localparam int PDCR_PLL_W = 21;
  localparam int PDCR_CONV_W = 16;
  localparam logic [4:0] PDCR_ADDR_PLL = 5'h04;
  localparam logic [4:0] PDCR_ADDR_I = 5'h05;
  localparam logic [4:0] PDCR_ADDR_AUX1 = 5'h06;
  localparam logic [4:0] PDCR_ADDR_Q = 5'h07;

  // ****************************************************************
  // reset values and write masks
  // ****************************************************************
  localparam logic [20:0] PDCR_PLL_RESET = 21'h00000;
  localparam logic [15:0] PDCR_CONV_RESET = 16'h0000;
  localparam logic [15:0] PDCR_AUX_RESET = 16'h0000;
  localparam logic [15:0] PDCR_CONV_WR_MASK = 16'hC3FF;
  localparam logic [15:0] PDCR_AUX_WR_MASK = 16'hE3FF;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PDCR_VCV_HI = 23;
  localparam int PDCR_VCV_LO = 21;
  localparam int PDCR_BW_HI = 20;
  localparam int PDCR_BW_LO = 16;
  localparam int PDCR_PLL_EN = 15;
  localparam int PDCR_VDIV_HI = 14;
  localparam int PDCR_VDIV_LO = 13;
  localparam int PDCR_LDIV_HI = 12;
  localparam int PDCR_LDIV_LO = 11;
  localparam int PDCR_BIAS_HI = 10;
  localparam int PDCR_BIAS_LO = 8;
  localparam int PDCR_BAND_HI = 7;
  localparam int PDCR_BAND_LO = 2;
  localparam int PDCR_DRIVE_HI = 1;
  localparam int PDCR_DRIVE_LO = 0;
  localparam int PDCR_SLEEP = 15;
  localparam int PDCR_PDOWN = 14;
  localparam int PDCR_AUX_SIGN = 15;
  localparam int PDCR_AUX_DIR = 14;
  localparam int PDCR_AUX_PDOWN = 13;
  localparam int PDCR_GAIN_HI = 9;
  localparam int PDCR_GAIN_LO = 0;

  // ****************************************************************
  // recommended codes
  // ****************************************************************
  localparam logic [2:0] PDCR_VCV_CENTRED = 3'h3;
  localparam logic [4:0] PDCR_BW_BEST = 5'h0F;
  localparam logic [2:0] PDCR_BIAS_BEST = 3'h3;
  localparam logic [1:0] PDCR_DRIVE_BEST = 2'h3;

  // ****************************************************************
  // serial framing
  // ****************************************************************
  localparam int PDCR_READ_BIT = 7;
  localparam logic [2:0] PDCR_LAST_BIT = 3'h7;
  localparam logic [1:0] PDCR_LAST_BYTE_LONG = 2'h2;
  localparam logic [1:0] PDCR_LAST_BYTE_SHORT = 2'h1;
  localparam int PDCR_SYNC_W = 6;
  localparam logic [5:0] PDCR_SYNC_RESET = 6'h02;

  typedef enum logic [1:0] {
    PDCR_ST_IDLE,
    PDCR_ST_INSTR,
    PDCR_ST_DATA,
    PDCR_ST_DONE
  } pdcr_state_t;
endpackage : pdcr_pkg

// *** pdcr_sync_if.sv ***
// Purpose: carries raw pin levels to the synchroniser and settled levels back
// Assumes: one clock domain
// Notes: width set by parameter
`timescale 1ns/1ps

// ****************************************************************
// synchroniser carrier
// ****************************************************************
interface pdcr_sync_if #(parameter int W = 6);
  logic [W-1:0] raw;
  logic [W-1:0] settled;
  modport syncer (input raw, output settled);
  modport user (output raw, input settled);
endinterface : pdcr_sync_if

// *** pdcr_pin_sync.sv ***
// Purpose: three stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_in
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps

// ****************************************************************
// pin synchroniser
// ****************************************************************
module pdcr_pin_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  pdcr_sync_if.syncer pins
);
  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] settled_reg;
  logic [W-1:0] agree;

  assign agree = ~(ff2_reg ^ ff3_reg);
  assign pins.settled = settled_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ff1_reg <= RESET_VAL;
      ff2_reg <= RESET_VAL;
      ff3_reg <= RESET_VAL;
      settled_reg <= RESET_VAL;
    end else begin
      ff1_reg <= pins.raw;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      settled_reg <= (agree & ff3_reg) | (~agree & settled_reg);
    end
  end
endmodule : pdcr_pin_sync

// *** pdcr_regs.sv ***
// Purpose: clock multiplier and converter control bank behind the serial port
// Assumes: serial clock high and low phases each last at least five clk_in periods
// Notes: fields drive the analog periphery straight from flip-flops
`timescale 1ns/1ps

module pdcr_regs (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_out,
  input wire logic [2:0] vco_ctrl_voltage_in,
  output logic vco_ctrl_centred_out,
  output logic [4:0] loop_bandwidth_out,
  output logic pll_enable_out,
  output logic sample_clk_from_ref_out,
  output logic [1:0] vco_div_code_out,
  output logic [3:0] vco_div_ratio_out,
  output logic [1:0] loop_div_code_out,
  output logic [4:0] loop_div_ratio_out,
  output logic [2:0] vco_bias_out,
  output logic [5:0] band_select_out,
  output logic [1:0] vco_drive_out,
  output logic pll_settings_optimal_out,
  output logic i_sleep_out,
  output logic i_powerdown_out,
  output logic i_active_out,
  output logic [9:0] i_gain_out,
  output logic aux1_negative_out,
  output logic aux1_pos_pin_active_out,
  output logic aux1_neg_pin_active_out,
  output logic aux1_sink_out,
  output logic aux1_powerdown_out,
  output logic [9:0] aux1_data_out,
  output logic q_sleep_out,
  output logic q_powerdown_out,
  output logic q_active_out,
  output logic [9:0] q_gain_out
);
  import pdcr_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [4:0] pdcr_ratio(input logic [1:0] code, input logic [4:0] base);
    pdcr_ratio = base << code;
  endfunction : pdcr_ratio

  function automatic logic [1:0] pdcr_last_byte(input logic [4:0] addr);
    if (addr == PDCR_ADDR_PLL) begin
      pdcr_last_byte = PDCR_LAST_BYTE_LONG;
    end else begin
      pdcr_last_byte = PDCR_LAST_BYTE_SHORT;
    end
  endfunction : pdcr_last_byte

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pdcr_sync_if #(.W(PDCR_SYNC_W)) pin_if ();

  pdcr_pin_sync #(
    .W(PDCR_SYNC_W),
    .RESET_VAL(PDCR_SYNC_RESET)
  ) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .pins(pin_if.syncer)
  );

  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic [2:0] vcv_s;

  assign pin_if.raw = {vco_ctrl_voltage_in, sdio_in, cs_n_in, sclk_in};
  assign sclk_s = pin_if.settled[0];
  assign cs_n_s = pin_if.settled[1];
  assign sdi_s = pin_if.settled[2];
  assign vcv_s = pin_if.settled[5:3];

  // ****************************************************************
  // control voltage code capture
  // ****************************************************************
  // code bits settle one by one, so take the word once two cycles agree
  logic [2:0] vcv_d_reg;
  logic [2:0] vcv_reg;
  logic vcv_steady;

  assign vcv_steady = vcv_s == vcv_d_reg;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      vcv_d_reg <= PDCR_SYNC_RESET[5:3];
      vcv_reg <= PDCR_SYNC_RESET[5:3];
    end else begin
      vcv_d_reg <= vcv_s;
      if (vcv_steady) begin
        vcv_reg <= vcv_d_reg;
      end
    end
  end

  // ****************************************************************
  // serial framing state
  // ****************************************************************
  pdcr_state_t state_reg;
  pdcr_state_t state_next;
  logic sclk_d_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [1:0] byte_cnt_reg;
  logic [1:0] byte_cnt_next;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic [4:0] addr_reg;
  logic [4:0] addr_next;
  logic rd_mode_reg;
  logic rd_mode_next;
  logic load_pend_reg;
  logic load_pend_next;
  logic [23:0] rd_shift_reg;
  logic [23:0] rd_shift_next;
  logic sdo_oe_reg;
  logic sdo_oe_next;

  logic frame_active;
  logic sclk_rise;
  logic sclk_fall;
  logic byte_done;
  logic last_byte;
  logic commit;
  logic [23:0] sample_word;
  logic [23:0] read_value;
  logic [23:0] rd_aligned;

  assign frame_active = ~cs_n_s;
  assign sclk_rise = sclk_s & ~sclk_d_reg;
  assign sclk_fall = ~sclk_s & sclk_d_reg;
  assign sample_word = {shift_reg[22:0], sdi_s};
  assign byte_done = sclk_rise & (bit_cnt_reg == PDCR_LAST_BIT);
  assign last_byte = byte_cnt_reg == pdcr_last_byte(addr_reg);
  assign commit = frame_active & (state_reg == PDCR_ST_DATA) & byte_done & last_byte
                  & ~rd_mode_reg;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    rd_mode_next = rd_mode_reg;
    load_pend_next = load_pend_reg;
    rd_shift_next = rd_shift_reg;
    case (state_reg)
      PDCR_ST_IDLE: begin
        bit_cnt_next = 3'h0;
        byte_cnt_next = 2'h0;
        load_pend_next = 1'b0;
        if (frame_active) begin
          state_next = PDCR_ST_INSTR;
        end
      end
      PDCR_ST_INSTR: begin
        if (sclk_rise) begin
          shift_next = sample_word;
          bit_cnt_next = bit_cnt_reg + 3'h1;
        end
        if (byte_done) begin
          addr_next = sample_word[4:0];
          rd_mode_next = sample_word[PDCR_READ_BIT];
          load_pend_next = sample_word[PDCR_READ_BIT];
          byte_cnt_next = 2'h0;
          state_next = PDCR_ST_DATA;
        end
      end
      PDCR_ST_DATA: begin
        if (sclk_rise) begin
          shift_next = sample_word;
          bit_cnt_next = bit_cnt_reg + 3'h1;
        end
        if (byte_done) begin
          if (last_byte) begin
            state_next = PDCR_ST_DONE;
          end else begin
            byte_cnt_next = byte_cnt_reg + 2'h1;
          end
        end
      end
      default: begin
        state_next = PDCR_ST_DONE;
      end
    endcase
    if (sclk_fall) begin
      if (load_pend_reg) begin
        rd_shift_next = rd_aligned;
        load_pend_next = 1'b0;
      end else if (state_reg == PDCR_ST_DATA) begin
        rd_shift_next = {rd_shift_reg[22:0], 1'b0};
      end
    end
    if (!frame_active) begin
      state_next = PDCR_ST_IDLE;
    end
  end

  assign sdo_oe_next = frame_active & rd_mode_reg & (state_next == PDCR_ST_DATA)
                       & (sdo_oe_reg | (sclk_fall & load_pend_reg));

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_reg <= PDCR_ST_IDLE;
      sclk_d_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
      shift_reg <= 24'h000000;
      addr_reg <= 5'h00;
      rd_mode_reg <= 1'b0;
      load_pend_reg <= 1'b0;
      rd_shift_reg <= 24'h000000;
      sdo_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sclk_d_reg <= sclk_s;
      bit_cnt_reg <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      rd_mode_reg <= rd_mode_next;
      load_pend_reg <= load_pend_next;
      rd_shift_reg <= rd_shift_next;
      sdo_oe_reg <= sdo_oe_next;
    end
  end

  assign sdio_out = rd_shift_reg[23];
  assign sdio_oe_out = sdo_oe_reg;

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [20:0] pll_cfg_reg;
  logic [15:0] i_ctl_reg;
  logic [15:0] aux1_ctl_reg;
  logic [15:0] q_ctl_reg;
  logic wr_pll;
  logic wr_i;
  logic wr_aux1;
  logic wr_q;

  assign wr_pll = commit & (addr_reg == PDCR_ADDR_PLL);
  assign wr_i = commit & (addr_reg == PDCR_ADDR_I);
  assign wr_aux1 = commit & (addr_reg == PDCR_ADDR_AUX1);
  assign wr_q = commit & (addr_reg == PDCR_ADDR_Q);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pll_cfg_reg <= PDCR_PLL_RESET;
      i_ctl_reg <= PDCR_CONV_RESET;
      aux1_ctl_reg <= PDCR_AUX_RESET;
      q_ctl_reg <= PDCR_CONV_RESET;
    end else begin
      if (wr_pll) begin
        pll_cfg_reg <= sample_word[20:0];
      end
      if (wr_i) begin
        i_ctl_reg <= sample_word[15:0] & PDCR_CONV_WR_MASK;
      end
      if (wr_aux1) begin
        aux1_ctl_reg <= sample_word[15:0] & PDCR_AUX_WR_MASK;
      end
      if (wr_q) begin
        q_ctl_reg <= sample_word[15:0] & PDCR_CONV_WR_MASK;
      end
    end
  end

  // ****************************************************************
  // readback
  // ****************************************************************
  always_comb begin
    if (addr_reg == PDCR_ADDR_PLL) begin
      read_value = {vcv_reg, pll_cfg_reg};
    end else if (addr_reg == PDCR_ADDR_I) begin
      read_value = {8'h00, i_ctl_reg};
    end else if (addr_reg == PDCR_ADDR_AUX1) begin
      read_value = {8'h00, aux1_ctl_reg};
    end else if (addr_reg == PDCR_ADDR_Q) begin
      read_value = {8'h00, q_ctl_reg};
    end else begin
      read_value = 24'h000000;
    end
  end

  assign rd_aligned = (addr_reg == PDCR_ADDR_PLL) ? read_value : {read_value[15:0], 8'h00};

  // ****************************************************************
  // analog periphery fields
  // ****************************************************************
  logic [4:0] vco_div_ratio_wide;

  assign vco_ctrl_centred_out = vcv_reg == PDCR_VCV_CENTRED;
  assign loop_bandwidth_out = pll_cfg_reg[PDCR_BW_HI:PDCR_BW_LO];
  assign pll_enable_out = pll_cfg_reg[PDCR_PLL_EN];
  assign sample_clk_from_ref_out = ~pll_cfg_reg[PDCR_PLL_EN];
  assign vco_div_code_out = pll_cfg_reg[PDCR_VDIV_HI:PDCR_VDIV_LO];
  assign vco_div_ratio_wide = pdcr_ratio(vco_div_code_out, 5'h01);
  assign vco_div_ratio_out = vco_div_ratio_wide[3:0];
  assign loop_div_code_out = pll_cfg_reg[PDCR_LDIV_HI:PDCR_LDIV_LO];
  assign loop_div_ratio_out = pdcr_ratio(loop_div_code_out, 5'h02);
  assign vco_bias_out = pll_cfg_reg[PDCR_BIAS_HI:PDCR_BIAS_LO];
  assign band_select_out = pll_cfg_reg[PDCR_BAND_HI:PDCR_BAND_LO];
  assign vco_drive_out = pll_cfg_reg[PDCR_DRIVE_HI:PDCR_DRIVE_LO];
  assign pll_settings_optimal_out = (loop_bandwidth_out == PDCR_BW_BEST)
                                    & (vco_bias_out == PDCR_BIAS_BEST)
                                    & (vco_drive_out == PDCR_DRIVE_BEST);

  assign i_sleep_out = i_ctl_reg[PDCR_SLEEP];
  assign i_powerdown_out = i_ctl_reg[PDCR_PDOWN];
  assign i_active_out = ~(i_sleep_out | i_powerdown_out);
  assign i_gain_out = i_ctl_reg[PDCR_GAIN_HI:PDCR_GAIN_LO];

  assign aux1_negative_out = aux1_ctl_reg[PDCR_AUX_SIGN];
  assign aux1_pos_pin_active_out = ~aux1_negative_out;
  assign aux1_neg_pin_active_out = aux1_negative_out;
  assign aux1_sink_out = aux1_ctl_reg[PDCR_AUX_DIR];
  assign aux1_powerdown_out = aux1_ctl_reg[PDCR_AUX_PDOWN];
  assign aux1_data_out = aux1_ctl_reg[PDCR_GAIN_HI:PDCR_GAIN_LO];

  assign q_sleep_out = q_ctl_reg[PDCR_SLEEP];
  assign q_powerdown_out = q_ctl_reg[PDCR_PDOWN];
  assign q_active_out = ~(q_sleep_out | q_powerdown_out);
  assign q_gain_out = q_ctl_reg[PDCR_GAIN_HI:PDCR_GAIN_LO];
endmodule : pdcr_regs

// *** pdcr_regs_asserts.sv ***
// Purpose: port-level checks for the multiplier and converter control bank
// Assumes: single clk_in domain, active low async reset
// Notes: attached by bind below
`timescale 1ns/1ps

// ****************************************************************
// checker
// ****************************************************************
module pdcr_regs_asserts (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic cs_n_in,
  input wire logic [2:0] vco_ctrl_voltage_in,
  input wire logic sdio_oe_out,
  input wire logic vco_ctrl_centred_out,
  input wire logic [4:0] loop_bandwidth_out,
  input wire logic pll_enable_out,
  input wire logic sample_clk_from_ref_out,
  input wire logic [1:0] vco_div_code_out,
  input wire logic [3:0] vco_div_ratio_out,
  input wire logic [1:0] loop_div_code_out,
  input wire logic [4:0] loop_div_ratio_out,
  input wire logic [2:0] vco_bias_out,
  input wire logic [1:0] vco_drive_out,
  input wire logic pll_settings_optimal_out,
  input wire logic i_sleep_out,
  input wire logic i_powerdown_out,
  input wire logic i_active_out,
  input wire logic [9:0] i_gain_out,
  input wire logic aux1_negative_out,
  input wire logic aux1_pos_pin_active_out,
  input wire logic aux1_neg_pin_active_out,
  input wire logic [9:0] aux1_data_out,
  input wire logic q_sleep_out,
  input wire logic q_powerdown_out,
  input wire logic q_active_out,
  input wire logic [9:0] q_gain_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  chk_clk_source:
    assert property (sample_clk_from_ref_out == !pll_enable_out)
    else $error("clock source select not inverse of enable");
  chk_vco_ratio:
    assert property (vco_div_ratio_out == (4'h1 << vco_div_code_out))
    else $error("vco ratio does not match its code");
  chk_loop_ratio:
    assert property (loop_div_ratio_out == (5'h02 << loop_div_code_out))
    else $error("loop ratio does not match its code");
  chk_best_settings:
    assert property (pll_settings_optimal_out == (loop_bandwidth_out == 5'h0F &&
      vco_bias_out == 3'h3 && vco_drive_out == 2'h3))
    else $error("optimal flag does not match the fields");
  chk_i_active:
    assert property (i_active_out == !(i_sleep_out || i_powerdown_out))
    else $error("i active flag wrong");
  chk_q_active:
    assert property (q_active_out == !(q_sleep_out || q_powerdown_out))
    else $error("q active flag wrong");
  chk_aux_pin_pick:
    assert property (aux1_neg_pin_active_out == aux1_negative_out &&
      aux1_pos_pin_active_out == !aux1_negative_out)
    else $error("aux pin choice does not follow sign");
  chk_vcv_centred:
    assert property ($stable(vco_ctrl_voltage_in) [*7] |->
      vco_ctrl_centred_out == (vco_ctrl_voltage_in == 3'h3))
    else $error("centred flag does not follow control voltage code");
  chk_fields_quiet:
    assert property (cs_n_in [*8] |-> $stable({loop_bandwidth_out, pll_enable_out,
      vco_div_code_out, loop_div_code_out, vco_bias_out, vco_drive_out, i_gain_out,
      aux1_data_out, q_gain_out, i_sleep_out, q_sleep_out, aux1_negative_out}))
    else $error("field changed with no frame in progress");
  chk_oe_idle:
    assert property (cs_n_in [*6] |-> !sdio_oe_out)
    else $error("data pin driven outside a frame");
endmodule : pdcr_regs_asserts

bind pdcr_regs pdcr_regs_asserts u_pdcr_regs_asserts (.*);

// *** tb_pdcr_regs.sv ***
// Purpose: register bank test through the serial port
// Assumes: sclk phases of 6 clk, inputs driven 1 ns after clk rise
// Notes: expectations built from field positions and codes
`timescale 1ns/1ps

// ****************************************************************
// testbench
// ****************************************************************
module tb_pdcr_regs;
  import pdcr_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, sclk_in = 1'b0, cs_n_in = 1'b1, sdio_in = 1'b0;
  logic [2:0] vco_ctrl_voltage_in = 3'h0;
  logic sdio_out, sdio_oe_out, vco_ctrl_centred_out, pll_enable_out, sample_clk_from_ref_out;
  logic pll_settings_optimal_out, i_sleep_out, i_powerdown_out, i_active_out;
  logic aux1_negative_out, aux1_pos_pin_active_out, aux1_neg_pin_active_out, aux1_sink_out;
  logic aux1_powerdown_out, q_sleep_out, q_powerdown_out, q_active_out;
  logic [1:0] vco_div_code_out, loop_div_code_out, vco_drive_out;
  logic [2:0] vco_bias_out;
  logic [3:0] vco_div_ratio_out;
  logic [4:0] loop_bandwidth_out, loop_div_ratio_out;
  logic [5:0] band_select_out;
  logic [9:0] i_gain_out, aux1_data_out, q_gain_out;
  logic [15:0] d;
  logic [23:0] p;
  logic [15:0] tbl [3] = '{16'hFFFF, 16'h8123, 16'h4000};
  logic [15:0] atbl [4] = '{16'hFFFF, 16'h8000, 16'h4155, 16'h2000};
  int fails = 0, cmp_count = 0, cycles = 0;

  pdcr_regs u_pdcr_regs (.*);

  always #10 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one frame: instruction byte then nbytes, msb first
  task automatic xfer(input logic rd, input logic [4:0] a, input int nbytes,
      input logic [23:0] wd, output logic [23:0] rdata);
    logic [31:0] frame;
    frame = {rd, 2'b00, a, 24'h000000} | (({8'h00, wd} << ((3 - nbytes) * 8)) & 32'h00FFFFFF);
    rdata = 24'h000000;
    cs_n_in = 1'b0;
    for (int i = 0; i < 8 + 8 * nbytes; i++) begin
      sdio_in = frame[31 - i];
      tick(6);
      if (i >= 8) begin
        rdata = {rdata[22:0], sdio_out};
        check("sdio_oe", rd, sdio_oe_out);
      end
      sclk_in = 1'b1;
      tick(6);
      sclk_in = 1'b0;
    end
    tick(6);
    cs_n_in = 1'b1;
    tick(8);
  endtask : xfer

  task automatic wr(input logic [4:0] a, input int n, input logic [23:0] wd);
    logic [23:0] r;
    xfer(1'b0, a, n, wd, r);
  endtask : wr

  task automatic rdchk(input string name, input logic [4:0] a, input int n,
      input logic [23:0] exp);
    logic [23:0] r;
    xfer(1'b1, a, n, 24'h000000, r);
    check(name, exp, r);
  endtask : rdchk

  initial begin
    tick(2);
    reset_n_in = 1'b1;
    tick(6);
    check("ref_clock_path", 2'h1, {pll_enable_out, sample_clk_from_ref_out});
    check("div_ratios", {4'h1, 5'h02}, {vco_div_ratio_out, loop_div_ratio_out});
    check("active_flags", 3'h7, {i_active_out, q_active_out, aux1_pos_pin_active_out});
    check("aux_bits", 3'h0, {aux1_negative_out, aux1_sink_out, aux1_powerdown_out});
    rdchk("i_reset", PDCR_ADDR_I, 2, 24'h000000);
    rdchk("aux_reset", PDCR_ADDR_AUX1, 2, 24'h000000);
    rdchk("q_reset", PDCR_ADDR_Q, 2, 24'h000000);
    for (int c = 0; c < 4; c++) begin
      p = {3'h0, 5'h0F, 1'b1, 2'(c), 2'(c), 3'h3, 6'h15 ^ 6'(c), 2'h3};
      wr(PDCR_ADDR_PLL, 3, p);
      check("vco_ratio", 4'h1 << c, vco_div_ratio_out);
      check("loop_ratio", 5'h02 << c, loop_div_ratio_out);
      check("pll_on", 2'h2, {pll_enable_out, sample_clk_from_ref_out});
      check("optimal", 1'b1, pll_settings_optimal_out);
      check("band", 6'h15 ^ 6'(c), band_select_out);
    end
    vco_ctrl_voltage_in = 3'h5;
    wr(PDCR_ADDR_PLL, 3, 24'hFFFFFF);
    rdchk("pll_read", PDCR_ADDR_PLL, 3, 24'hBFFFFF);
    check("pll_fields", {5'h1F, 3'h7, 2'h3, 1'b0},
      {loop_bandwidth_out, vco_bias_out, vco_drive_out, pll_settings_optimal_out});
    check("not_centred", 1'b0, vco_ctrl_centred_out);
    vco_ctrl_voltage_in = 3'h3;
    tick(8);
    check("centred", 1'b1, vco_ctrl_centred_out);
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 3; k++) begin
        d = tbl[k];
        wr(ch ? PDCR_ADDR_Q : PDCR_ADDR_I, 2, d);
        check("conv_state", {d[15], d[14], !(d[15] | d[14]), d[9:0]}, ch ?
          {q_sleep_out, q_powerdown_out, q_active_out, q_gain_out} :
          {i_sleep_out, i_powerdown_out, i_active_out, i_gain_out});
        rdchk("conv_read", ch ? PDCR_ADDR_Q : PDCR_ADDR_I, 2, d & 16'hC3FF);
      end
    end
    foreach (atbl[k]) begin
      d = atbl[k];
      wr(PDCR_ADDR_AUX1, 2, d);
      check("aux_state", {d[15], !d[15], d[15], d[14], d[13], d[9:0]},
        {aux1_negative_out, aux1_pos_pin_active_out, aux1_neg_pin_active_out,
        aux1_sink_out, aux1_powerdown_out, aux1_data_out});
      rdchk("aux_read", PDCR_ADDR_AUX1, 2, d & 16'hE3FF);
    end
    wr(5'h08, 2, 24'h00FFFF);
    rdchk("unmapped", 5'h08, 2, 24'h000000);
    check("q_kept", 10'h000, q_gain_out);
    wr(PDCR_ADDR_I, 1, 24'h0000FF);
    rdchk("short_frame", PDCR_ADDR_I, 2, 24'h004000);
    reset_n_in = 1'b0;
    tick(2);
    reset_n_in = 1'b1;
    tick(6);
    check("rereset", {1'b0, 10'h000}, {pll_enable_out, aux1_data_out});
    test_done();
  end
endmodule : tb_pdcr_regs
